// ==== pkg/gpid_pkg.sv ====
`default_nettype none
package gpid_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int GPID_PORTS = 4;
  localparam int GPID_PINS = 16;
  localparam int GPID_ALL = 64;
  localparam int GPID_AF_W = 4;
  localparam int GPID_AF_PER_REG = 8;
  // Ports A,B full, C eight pins, D five pins: 45 in all
  localparam logic [63:0] GPID_PRESENT = 64'h001f_00ff_ffff_ffff;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] GPID_DIR_RST = 16'hffff;
  localparam logic [15:0] GPID_ZERO16 = 16'h0000;
  localparam logic [31:0] GPID_ZERO32 = 32'h0000_0000;
  localparam logic [3:0] GPID_AF_ZERO = 4'h0;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int GPID_SET_LSB = 0;
  localparam int GPID_CLR_LSB = 16;
  localparam int GPID_DBC_CNT_LSB = 0;
  localparam int GPID_DBC_DIV_LSB = 8;
  localparam int GPID_DBC_EN_BIT = 11;
  localparam int GPID_OD_LSB = 0;
  localparam int GPID_DRV_LSB = 16;
  localparam int GPID_PULL_UP_OFS = 0;
  localparam int GPID_PULL_DN_OFS = 1;

  // ------------------------------------------------------------
  // Register selects, one-hot
  // ------------------------------------------------------------
  typedef enum logic [13:0] {
    GPID_SEL_DATA = 14'h0001,
    GPID_SEL_DIR = 14'h0002,
    GPID_SEL_SETCLR = 14'h0004,
    GPID_SEL_DBC = 14'h0008,
    GPID_SEL_POL = 14'h0010,
    GPID_SEL_SENSE = 14'h0020,
    GPID_SEL_IEN = 14'h0040,
    GPID_SEL_IDIS = 14'h0080,
    GPID_SEL_ISC = 14'h0100,
    GPID_SEL_PULL = 14'h0200,
    GPID_SEL_OTD = 14'h0400,
    GPID_SEL_AFL = 14'h0800,
    GPID_SEL_AFH = 14'h1000,
    GPID_SEL_ANALOG = 14'h2000
  } gpid_sel_t;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
    gpid_sel_t sel;
    logic [31:0] data;
  } gpid_cmd_t;

  typedef struct packed {
    logic [15:0] data_rd;
    logic [15:0] dir;
    logic [15:0] mask;
    logic [15:0] raw;
    logic [15:0] masked;
    logic [11:0] dbc;
  } gpid_stat_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic open_drain;
    logic drive;
    logic [3:0] af;
  } gpid_pad_t;

  typedef struct packed {
    logic [15:0] data_out;
    logic [15:0] dir;
    logic [15:0] mask;
    logic [15:0] pol;
    logic [15:0] sense;
    logic [15:0] analog;
    logic [11:0] dbc;
    logic [31:0] pull;
    logic [31:0] otd;
    logic [31:0] afl;
    logic [31:0] afh;
    logic [2:0] div_cnt;
  } gpid_port_t;
endpackage
`default_nettype wire

// ==== verilog/gpid_debounce.sv ====
`default_nettype none
module gpid_debounce
  import gpid_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic srst_b, // synchronised reset, low active
  input wire logic pin, // raw pad level
  input wire logic enable, // debounce on
  input wire logic tick, // divided sample strobe
  input wire logic [7:0] match, // samples needed minus one
  output logic level // filtered level
);
  typedef struct packed {
    logic sample_stage_first;
    logic sample_stage_second;
    logic sample_stage_third;
    logic filt;
    logic [7:0] count;
  } gpid_deb_t;

  gpid_deb_t s;
  gpid_deb_t next_s;

  always_comb begin
    next_s = s;
    next_s.sample_stage_first = pin;
    next_s.sample_stage_second = s.sample_stage_first;
    next_s.sample_stage_third = s.sample_stage_second;
    if (!enable) begin
      next_s.filt = s.sample_stage_second;
      next_s.count = 8'h00;
    end else if (s.sample_stage_second != s.sample_stage_third) begin
      next_s.count = 8'h00;
    end else if (tick) begin
      if (s.sample_stage_third == s.filt) begin
        next_s.count = 8'h00;
      end else if (s.count == match) begin
        next_s.filt = s.sample_stage_third;
        next_s.count = 8'h00;
      end else begin
        next_s.count = s.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.filt;
endmodule // gpid_debounce
`default_nettype wire

// ==== verilog/gpid_irq_detect.sv ====
`default_nettype none
module gpid_irq_detect
  import gpid_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic srst_b, // synchronised reset, low active
  input wire logic level, // filtered pin level
  input wire logic allowed, // pin may raise events
  input wire logic sense, // 1 level, 0 edge
  input wire logic pol, // 1 rising/high, 0 falling/low
  input wire logic clear, // clear pulse from software
  output logic raw // sticky detected condition
);
  typedef struct packed {
    logic prev;
    logic raw;
  } gpid_det_t;

  gpid_det_t s;
  gpid_det_t next_s;
  logic cond;

  always_comb begin
    next_s = s;
    if (sense) begin
      cond = (level == pol);
    end else if (pol) begin
      cond = level & ~s.prev;
    end else begin
      cond = ~level & s.prev;
    end
    next_s.prev = level;
    // Set beats a clear in the same cycle, so no event is lost
    next_s.raw = (s.raw & ~clear) | (allowed & cond);
  end

  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign raw = s.raw;
endmodule // gpid_irq_detect
`default_nettype wire

// ==== verilog/gpid_gpio.sv ====
// Contract
// - 45 pins in 4 ports, per-pin control
// - After reset all pins float
// - Data reads pin input, holds output value
// - Direction defaults input; 0 drives data
// - Set/clear touches only the written bits
// - Interrupts disabled after reset
// - No events for outputs or peripheral mode
// - Enable write of 1 unmasks pin
// - Disable write of 1 masks pin
// - Mask status shows net enable state
// - Raw status shows all detected conditions
// - Masked status only unmasked; only those forwarded
// - Writing 1 to masked status clears
// - Edge rise/fall or level high/low
// - Analog: no output, input reads 0
// - One alternate function per pin, default zero
// - Pull, output type and drive per pin
// - Three sample stages; second when unfiltered
// - Filter time (divider+1)*(count+1) clocks
// - Stage mismatch clears count; update at match
// - 16-bit data/direction, direction resets ones
`default_nettype none
module gpid_gpio
  import gpid_pkg::*;
(
  input wire logic clock, // system clock, 20 MHz
  input wire logic rst_b, // asynchronous reset, low active
  input wire gpid_cmd_t cmd, // register write command
  input wire logic [63:0] pad_in, // pad levels, port*16+pin
  input wire logic [63:0] periph_out, // peripheral output values
  input wire logic [63:0] periph_oe, // peripheral output enables
  output gpid_pad_t [63:0] pad, // pad controls
  output logic [63:0] periph_in, // filtered levels to peripherals
  output gpid_stat_t [3:0] stat, // readable state per port
  output logic [3:0] irq // interrupt request per port
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    gpid_port_t [3:0] port;
    gpid_pad_t [63:0] pad;
    logic [63:0] periph_in;
    gpid_stat_t [3:0] stat;
    logic [3:0] irq;
  } gpid_top_t;

  gpid_top_t s;
  gpid_top_t next_s;
  logic [1:0] rst_q;
  logic srst_b;
  logic [3:0] tick;
  logic [63:0] filt;
  logic [63:0] level;
  logic [63:0] allowed;
  logic [63:0] sense;
  logic [63:0] pol;
  logic [63:0] clear;
  logic [63:0] raw;
  logic [63:0] dbc_en;
  logic [63:0][7:0] dbc_match;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign srst_b = rst_q[1];

  // ------------------------------------------------------------
  // Per-pin filter and event detection
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < GPID_ALL; g++) begin : g_pin
      gpid_debounce u_deb (
        .clock(clock),
        .srst_b(srst_b),
        .pin(pad_in[g]),
        .enable(dbc_en[g]),
        .tick(tick[g / GPID_PINS]),
        .match(dbc_match[g]),
        .level(filt[g])
      );
      gpid_irq_detect u_det (
        .clock(clock),
        .srst_b(srst_b),
        .level(level[g]),
        .allowed(allowed[g]),
        .sense(sense[g]),
        .pol(pol[g]),
        .clear(clear[g]),
        .raw(raw[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] af;
    logic hw;
    logic od;
    logic [15:0] d16;
    int k;
    next_s = s;
    tick = 4'h0;
    level = '0;
    allowed = '0;
    sense = '0;
    pol = '0;
    clear = '0;
    dbc_en = '0;
    dbc_match = '0;
    af = GPID_AF_ZERO;
    hw = 1'b0;
    od = 1'b0;
    k = 0;
    d16 = cmd.data[15:0];

    // Register writes; only bits written as 1 act on the W1 registers
    if (cmd.valid) begin
      case (cmd.sel)
        GPID_SEL_DATA: begin
          next_s.port[cmd.port].data_out = d16;
        end
        GPID_SEL_DIR: begin
          next_s.port[cmd.port].dir = d16;
        end
        GPID_SEL_SETCLR: begin
          // Set wins if a bit is both set and cleared
          next_s.port[cmd.port].data_out =
            (s.port[cmd.port].data_out
             & ~cmd.data[GPID_CLR_LSB +: GPID_PINS])
            | cmd.data[GPID_SET_LSB +: GPID_PINS];
        end
        GPID_SEL_DBC: begin
          next_s.port[cmd.port].dbc = cmd.data[11:0];
        end
        GPID_SEL_POL: begin
          next_s.port[cmd.port].pol = d16;
        end
        GPID_SEL_SENSE: begin
          next_s.port[cmd.port].sense = d16;
        end
        GPID_SEL_IEN: begin
          next_s.port[cmd.port].mask =
            s.port[cmd.port].mask | d16;
        end
        GPID_SEL_IDIS: begin
          next_s.port[cmd.port].mask =
            s.port[cmd.port].mask & ~d16;
        end
        GPID_SEL_ISC: begin
          next_s.port[cmd.port] = s.port[cmd.port];
        end
        GPID_SEL_PULL: begin
          next_s.port[cmd.port].pull = cmd.data;
        end
        GPID_SEL_OTD: begin
          next_s.port[cmd.port].otd = cmd.data;
        end
        GPID_SEL_AFL: begin
          next_s.port[cmd.port].afl = cmd.data;
        end
        GPID_SEL_AFH: begin
          next_s.port[cmd.port].afh = cmd.data;
        end
        GPID_SEL_ANALOG: begin
          next_s.port[cmd.port].analog = d16;
        end
        default: begin
          next_s.port[cmd.port] = s.port[cmd.port];
        end
      endcase
    end

    for (int p = 0; p < GPID_PORTS; p++) begin
      // One shared sample divider per port
      tick[p] = (s.port[p].div_cnt ==
                 s.port[p].dbc[GPID_DBC_DIV_LSB +: 3]);
      next_s.port[p].div_cnt =
        tick[p] ? 3'h0 : s.port[p].div_cnt + 3'h1;

      for (int i = 0; i < GPID_PINS; i++) begin
        k = p * GPID_PINS + i;
        if (i < GPID_AF_PER_REG) begin
          af = s.port[p].afl[i * GPID_AF_W +: GPID_AF_W];
        end else begin
          af = s.port[p].afh[(i - GPID_AF_PER_REG) * GPID_AF_W +:
                             GPID_AF_W];
        end
        hw = (af != GPID_AF_ZERO);
        od = s.port[p].otd[GPID_OD_LSB + i];

        dbc_en[k] = s.port[p].dbc[GPID_DBC_EN_BIT];
        dbc_match[k] = s.port[p].dbc[GPID_DBC_CNT_LSB +: 8];
        // Analog pins cut the digital input to a steady 0
        level[k] = filt[k] & ~s.port[p].analog[i];
        allowed[k] = GPID_PRESENT[k] & s.port[p].dir[i]
                     & ~hw & ~s.port[p].analog[i];
        sense[k] = s.port[p].sense[i];
        pol[k] = s.port[p].pol[i];
        clear[k] = cmd.valid && (cmd.sel == GPID_SEL_ISC)
                   && (cmd.port == 2'(p)) && d16[i];

        // Pad drive: peripheral when an alternate function is chosen
        next_s.pad[k].af = GPID_PRESENT[k] ? af : GPID_AF_ZERO;
        if (hw) begin
          next_s.pad[k].out = periph_out[k];
          next_s.pad[k].oe = GPID_PRESENT[k] & periph_oe[k]
                             & ~s.port[p].analog[i];
        end else begin
          // Open drain only pulls low, released when data is 1
          next_s.pad[k].out = od ? 1'b0 : s.port[p].data_out[i];
          next_s.pad[k].oe = GPID_PRESENT[k] & ~s.port[p].dir[i]
                             & ~s.port[p].analog[i]
                             & (~od | ~s.port[p].data_out[i]);
        end
        next_s.pad[k].pull_up = GPID_PRESENT[k]
          & s.port[p].pull[2 * i + GPID_PULL_UP_OFS];
        next_s.pad[k].pull_dn = GPID_PRESENT[k]
          & s.port[p].pull[2 * i + GPID_PULL_DN_OFS];
        next_s.pad[k].open_drain = GPID_PRESENT[k] & od;
        next_s.pad[k].drive = GPID_PRESENT[k]
          & s.port[p].otd[GPID_DRV_LSB + i];
        next_s.periph_in[k] = GPID_PRESENT[k] & level[k];

        next_s.stat[p].data_rd[i] = s.port[p].dir[i]
          ? (GPID_PRESENT[k] & level[k])
          : s.port[p].data_out[i];
        next_s.stat[p].raw[i] = raw[k];
        next_s.stat[p].masked[i] =
          raw[k] & s.port[p].mask[i];
      end
      next_s.stat[p].dir = s.port[p].dir;
      next_s.stat[p].mask = s.port[p].mask;
      next_s.stat[p].dbc = s.port[p].dbc;
      next_s.irq[p] = |(raw[p * GPID_PINS +: GPID_PINS]
                        & s.port[p].mask);
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge srst_b) begin
    if (!srst_b) begin
      s <= '0;
      for (int p = 0; p < GPID_PORTS; p++) begin
        s.port[p].dir <= GPID_DIR_RST;
        s.stat[p].dir <= GPID_DIR_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  assign pad = s.pad;
  assign periph_in = s.periph_in;
  assign stat = s.stat;
  assign irq = s.irq;
endmodule // gpid_gpio
`default_nettype wire

// ==== verification/gpid_gpio_properties.sv ====
`default_nettype none
module gpid_gpio_properties
  import gpid_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_b, // reset, low active
  input wire gpid_cmd_t cmd, // write command
  input wire logic [63:0] pad_in, // pad levels
  input wire logic [63:0] periph_out, // peripheral values
  input wire logic [63:0] periph_oe, // peripheral enables
  input wire gpid_pad_t [63:0] pad, // pad controls
  input wire logic [63:0] periph_in, // filtered levels
  input wire gpid_stat_t [3:0] stat, // port state
  input wire logic [3:0] irq // port requests
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_wr(p, s);
    cmd.valid && cmd.port == p && cmd.sel == s;
  endsequence
  a_reset_quiet: assert property ($rose(rst_b) |-> ##1
    (irq == 4'h0 && stat[1].mask == 16'h0000 && !pad[0].oe))
    else $error("outputs active after reset");
  a_dir_write: assert property (s_wr(2'h0, GPID_SEL_DIR) |-> ##2
    stat[0].dir == $past(cmd.data[15:0], 2))
    else $error("direction write not seen");
  a_enable_set: assert property (s_wr(2'h1, GPID_SEL_IEN) |-> ##2
    (stat[1].mask & $past(cmd.data[15:0], 2)) == $past(cmd.data[15:0], 2))
    else $error("enable did not unmask");
  a_disable_clr: assert property (s_wr(2'h1, GPID_SEL_IDIS) |-> ##2
    (stat[1].mask & $past(cmd.data[15:0], 2)) == 16'h0000)
    else $error("disable did not mask");
  a_mask_cause: assert property ($changed(stat[1].mask) |->
    $past(cmd.valid && cmd.port == 2'h1 &&
    (cmd.sel == GPID_SEL_IEN || cmd.sel == GPID_SEL_IDIS), 2))
    else $error("mask changed without a write");
  a_masked_view: assert property (
    stat[1].masked == (stat[1].raw & stat[1].mask))
    else $error("masked status wrong");
  a_irq_pending: assert property (
    irq[1] == (|stat[1].masked) && irq[0] == (|stat[0].masked))
    else $error("request disagrees with pending");
  a_raw_clear: assert property ($fell(stat[1].raw[0]) |->
    $past(cmd.valid && cmd.port == 2'h1 && cmd.sel == GPID_SEL_ISC &&
    cmd.data[0], 2))
    else $error("raw bit dropped without clear");
  a_absent_idle: assert property (
    !pad[40].oe && !pad[63].oe && !periph_in[63])
    else $error("absent pin active");
endmodule // gpid_gpio_properties
bind gpid_gpio gpid_gpio_properties u_props (.clock(clock), .rst_b(rst_b),
  .cmd(cmd), .pad_in(pad_in), .periph_out(periph_out),
  .periph_oe(periph_oe), .pad(pad), .periph_in(periph_in), .stat(stat),
  .irq(irq));
`default_nettype wire

// ==== verification/gpid_pad_model.sv ====
`default_nettype none
module gpid_pad_model
  import gpid_pkg::*;
(
  input wire logic clock, // system clock
  input wire gpid_pad_t [63:0] pad, // pad controls
  input wire logic [63:0] ext_oe, // outside driver on
  input wire logic [63:0] ext_val, // outside level
  output logic [63:0] pad_in // resolved pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wander = 1'b0;
  // Undriven pins without pull wander, so no level is ever assumed
  always @(posedge clock) wander <= !wander;
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pad[i].oe) pad_in[i] = pad[i].out;
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else if (pad[i].pull_up) pad_in[i] = 1'b1;
      else if (pad[i].pull_dn) pad_in[i] = 1'b0;
      else pad_in[i] = wander ^ i[0];
    end
  end
endmodule // gpid_pad_model
`default_nettype wire

// ==== verification/tb_gpio_port_irq_debounce.sv ====
`default_nettype none
module tb_gpio_port_irq_debounce
  import gpid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  gpid_cmd_t cmd = '0;
  logic [63:0] ext_oe = 64'h0000_0001_000f_0100;
  logic [63:0] ext_val = 64'h0000_0000_000a_0100;
  // Peripheral drives pin 9 of port A once it is handed an alternate function
  logic [63:0] periph_drv = 64'h0000_0000_0000_0200;
  logic [63:0] pad_in;
  gpid_pad_t [63:0] pad;
  logic [63:0] periph_in;
  gpid_stat_t [3:0] stat;
  logic [3:0] irq;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic held;
  always #25 clock = !clock;
  gpid_gpio DUT (.clock(clock), .rst_b(rst_b), .cmd(cmd), .pad_in(pad_in),
    .periph_out(periph_drv), .periph_oe(periph_drv), .pad(pad),
    .periph_in(periph_in), .stat(stat), .irq(irq));
  gpid_pad_model u_far (.clock(clock), .pad(pad), .ext_oe(ext_oe),
    .ext_val(ext_val), .pad_in(pad_in));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // State shows two edges after the command edge
  task automatic wr(input logic [1:0] p, input gpid_sel_t s,
      input logic [31:0] d);
    @(posedge clock);
    cmd <= '{valid: 1'b1, port: p, sel: s, data: d};
    @(posedge clock);
    cmd.valid <= 1'b0;
    wt(2);
  endtask
  task automatic settle(input int i, input logic v);
    @(posedge clock);
    ext_val[i] <= v;
    n = 0;
    do begin
      wt(1);
      n++;
    end while (periph_in[i] !== v && n < 40);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    wt(3);
    for (int i = 0; i < 64; i++) begin
      chk(pad[i].oe | pad[i].pull_up | pad[i].pull_dn, 0);
      chk(pad[i].af, 0);
    end
    for (int p = 0; p < 4; p++) begin
      chk(stat[p].dir, 16'hffff);
      chk(stat[p].mask | irq[p], 0);
    end
    wr(0, GPID_SEL_DATA, 32'h00a5);
    wr(0, GPID_SEL_DIR, 32'hff00);
    chk(stat[0].data_rd[8:0], 9'h1a5);
    chk({pad[0].oe, pad[0].out, pad[1].oe, pad[1].out}, 4'he);
    wr(0, GPID_SEL_SETCLR, 32'h0085_0082);
    chk(stat[0].data_rd[7:0], 8'ha2);
    wr(0, GPID_SEL_SETCLR, 32'h0);
    chk(stat[0].data_rd[7:0], 8'ha2);
    wr(1, GPID_SEL_SENSE, 32'h000c);
    wr(1, GPID_SEL_POL, 32'h0005);
    wr(1, GPID_SEL_ISC, 32'hffff);
    chk(stat[1].raw[3:0], 0);
    wr(1, GPID_SEL_IEN, 32'h0001);
    chk(stat[1].mask, 16'h0001);
    @(posedge clock);
    ext_val[19:16] <= 4'h5;
    wt(8);
    chk(stat[1].raw[3:0], 4'hf);
    chk({stat[1].masked[3:0], irq[1]}, 5'h03);
    wr(1, GPID_SEL_IDIS, 32'h0001);
    chk({stat[1].mask, irq[1]}, 0);
    wr(1, GPID_SEL_ISC, 32'h000f);
    chk(stat[1].raw[3:0], 4'hc);
    @(posedge clock);
    ext_val[19:16] <= 4'ha;
    wt(8);
    wr(1, GPID_SEL_ISC, 32'h000c);
    chk(stat[1].raw[3:0], 0);
    wr(1, GPID_SEL_DIR, 32'hffef);
    wr(1, GPID_SEL_AFL, 32'h0010_0000);
    wr(1, GPID_SEL_DATA, 32'h0010);
    wr(1, GPID_SEL_ISC, 32'h0030);
    wr(1, GPID_SEL_DATA, 32'h0);
    wt(8);
    chk(stat[1].raw[5:4], 0);
    wr(0, GPID_SEL_ANALOG, 32'h0101);
    wt(6);
    chk({pad[0].oe, periph_in[8], stat[0].data_rd[8]}, 0);
    settle(32, 1'b1);
    chk(n, 4);
    settle(32, 1'b0);
    wr(2, GPID_SEL_DBC, 32'h0b01);
    chk(stat[2].dbc, 12'hb01);
    settle(32, 1'b1);
    chk(n >= 8 && n <= 16, 1);
    @(posedge clock);
    ext_val[32] <= 1'b0;
    @(posedge clock);
    ext_val[32] <= 1'b1;
    held = 1'b1;
    repeat (20) begin
      wt(1);
      held = held & periph_in[32];
    end
    chk(held, 1);
    wr(3, GPID_SEL_PULL, 32'h0004);
    wr(3, GPID_SEL_OTD, 32'h0002_0002);
    chk({pad[49].pull_up, pad[49].pull_dn, pad[49].open_drain,
      pad[49].drive}, 4'hb);
    wr(0, GPID_SEL_AFH, 32'h0080);
    wr(3, GPID_SEL_AFL, 32'h0008);
    chk({pad[9].af, pad[48].af}, 8'h88);
    chk({pad[9].oe, pad[9].out}, 2'h3);
    wr(3, GPID_SEL_DIR, 32'h0);
    chk(pad[56].oe, 0);
    end_sim();
  end
endmodule // tb_gpio_port_irq_debounce
`default_nettype wire
